// ---- shared/csw_regs.svh ----
`ifndef CSW_REGS_SVH
`define CSW_REGS_SVH
// ======================================================================
// register offsets on the apb bus
`define CSW_OFF_UPPER   8'h00
`define CSW_OFF_LOWER   8'h04
`define CSW_OFF_MIDMEM  8'h08
`define CSW_OFF_PBASE   8'h0c
`define CSW_OFF_MIDPER  8'h10
`define CSW_OFF_STATUS  8'h14
// ======================================================================
// reset values
`define CSW_RST_UPPER   16'hf007
`define CSW_RST_LOWER   16'h0000
`define CSW_RST_MIDMEM  16'h0000
`define CSW_RST_PBASE   16'h0000
`define CSW_RST_MIDPER  16'h0000
// ======================================================================
// field positions
`define CSW_WAIT_MSB    1
`define CSW_WAIT_LSB    0
`define CSW_RDY_BIT     2
`define CSW_EXT_BIT     3
`define CSW_DA_BIT      7
`define CSW_AMODE_BIT   7
`define CSW_MSPACE_BIT  6
`define CSW_BOUND_MSB   15
`define CSW_BOUND_LSB   12
`define CSW_MBASE_MSB   15
`define CSW_MBASE_LSB   9
`define CSW_MSIZE_MSB   10
`define CSW_MSIZE_LSB   8
`define CSW_PBASE_MSB   15
`define CSW_PBASE_LSB   7
// ======================================================================
// wait counts
`define CSW_WAIT_X0     4'h5
`define CSW_WAIT_X1     4'h7
`define CSW_WAIT_X2     4'h9
`define CSW_WAIT_X3     4'hf
`define CSW_TAIL_WAITS  4'h2
`endif

// ---- shared/csw_pkg.sv ----
package csw_pkg;
   // ===================================================================
   // bus phase sequence
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_T1,
      PH_T2,
      PH_T3,
      PH_WAIT,
      PH_HOLD,
      PH_T4
   } csw_phase_e;

   // ===================================================================
   // ready and wait setting of one access
   typedef struct packed {
      logic [3:0] waits;
      logic       rdy_req;
   } csw_cfg_s;

   // ===================================================================
   // which selects an address hits
   typedef struct packed {
      logic       ucs;
      logic       lcs;
      logic [3:0] mcs;
      logic [6:0] pcs;
   } csw_hits_s;

   // ===================================================================
   // sequencer state
   typedef struct packed {
      csw_phase_e phase;
      logic [3:0] left;
      logic       first;
      logic       rdy_req;
      logic       done;
   } csw_wg_state_s;

   // ===================================================================
   // unit state
   typedef struct packed {
      logic [15:0] upper;
      logic [15:0] lower;
      logic [15:0] midmem;
      logic [15:0] pbase;
      logic [15:0] midper;
      logic        lcs_en;
      logic        mm_w;
      logic        mp_w;
      logic        pb_w;
      csw_hits_s   sel;
      logic        amode;
      logic        a1;
      logic        a2;
      logic        addr_en;
      logic        ardy_s1;
      logic        ardy_s2;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } csw_state_s;
endpackage

// ---- hw/csw_wait_gen.sv ----
`timescale 1ns/1ns
`include "csw_regs.svh"
module csw_wait_gen (
   // clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   // cycle request
   input  wire logic          i_start,
   input  csw_pkg::csw_cfg_s  i_cfg,
   input  wire logic          i_ready,
   // sequence state
   output csw_pkg::csw_phase_e o_phase,
   output logic               o_done
);
   csw_pkg::csw_wg_state_s s_r;
   csw_pkg::csw_wg_state_s s_nxt;

   // ===================================================================
   // phase sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      case (s_r.phase)
         csw_pkg::PH_IDLE: begin
            if (i_start) begin
               s_nxt.phase = csw_pkg::PH_T1;
               s_nxt.left = i_cfg.waits;
               s_nxt.rdy_req = i_cfg.rdy_req;
               s_nxt.first = 1'b1;
            end
         end
         csw_pkg::PH_T1: s_nxt.phase = csw_pkg::PH_T2;
         csw_pkg::PH_T2: s_nxt.phase = csw_pkg::PH_T3;
         csw_pkg::PH_T3: begin
            if (s_r.left != 4'h0) begin
               s_nxt.phase = csw_pkg::PH_WAIT;
            end else if (s_r.rdy_req && !i_ready) begin
               s_nxt.phase = csw_pkg::PH_HOLD;
            end else begin
               s_nxt.phase = csw_pkg::PH_T4;
               s_nxt.done = 1'b1;
            end
         end
         csw_pkg::PH_WAIT: begin
            s_nxt.first = 1'b0;
            if (s_r.first && s_r.rdy_req && !i_ready) begin
               s_nxt.phase = csw_pkg::PH_HOLD;
            end else begin
               s_nxt.left = s_r.left - 4'h1;
               if (s_r.left == 4'h1) begin
                  s_nxt.phase = csw_pkg::PH_T4;
                  s_nxt.done = 1'b1;
               end
            end
         end
         csw_pkg::PH_HOLD: begin
            if (i_ready) begin
               s_nxt.phase = csw_pkg::PH_WAIT;
               s_nxt.left = `CSW_TAIL_WAITS;
               s_nxt.first = 1'b0;
            end
         end
         csw_pkg::PH_T4: s_nxt.phase = csw_pkg::PH_IDLE;
         default: s_nxt.phase = csw_pkg::PH_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_r <= '{phase: csw_pkg::PH_IDLE, left: 4'h0, first: 1'b0,
                  rdy_req: 1'b0, done: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_phase = s_r.phase;
   assign o_done  = s_r.done;

   // ===================================================================
   // checks
   seven_cycle_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (s_r.phase == csw_pkg::PH_IDLE && i_start && i_cfg.waits == 4'h3 && i_cfg.rdy_req)
      ##4 i_ready |-> ##3 o_done)
      else $error("three waits with ready did not end in seven cycles");
   ready_tail_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (s_r.phase == csw_pkg::PH_HOLD && i_ready) |=> (o_phase == csw_pkg::PH_WAIT)
      ##1 (o_phase == csw_pkg::PH_WAIT) ##1 (o_phase == csw_pkg::PH_T4))
      else $error("two tail waits not inserted after ready");
endmodule

// ---- hw/csw_top.sv ----
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "csw_regs.svh"
module csw_top #(
   parameter int ADDR_W    = 20,
   parameter int MCS_COUNT = 4,
   parameter int PCS_COUNT = 7
) (
   // clock and reset
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_SYS_RST,
   // apb slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic             O_PREADY,
   output logic [31:0]      O_PRDATA,
   output logic             O_PSLVERR,
   // bus cycle from the bus unit
   input  wire logic        I_CYC_START,
   input  wire logic [19:0] I_CYC_ADDR,
   input  wire logic        I_CYC_IO,
   input  wire logic        I_CYC_DMA,
   input  wire logic        I_PCB_HIT,
   // external ready
   input  wire logic        I_ARDY,
   input  wire logic        I_SRDY,
   // selects and bus controls
   output logic             O_UCS_N,
   output logic             O_LCS_N,
   output logic [3:0]       O_MCS_N,
   output logic [3:0]       O_PCS_LOW_N,
   output logic             O_PERIPH_SELECT_SECOND_N,
   output logic             O_PERIPH_SELECT_TOP_N,
   output logic             O_ADDR_DRIVE_EN,
   output logic             O_CYC_DONE,
   output logic [2:0]       O_PHASE
);
   if (ADDR_W != 20 || MCS_COUNT != 4 || PCS_COUNT != 7) begin : g_bad_param
      $error("csw_top supports only a 20-bit address, 4 mcs and 7 pcs");
   end

   csw_pkg::csw_state_s  st_r;
   csw_pkg::csw_state_s  st_nxt;
   csw_pkg::csw_hits_s   hit;
   csw_pkg::csw_cfg_s    cfg;
   csw_pkg::csw_phase_e  phase;
   logic                 done;
   logic                 ready;
   logic                 mcs_en;
   logic                 pcs_en;
   logic                 mem_cyc;
   logic                 pcs_cyc;
   logic                 da_hit;
   logic [19:0]          moff;
   logic [19:0]          mbase;
   logic [19:0]          msize;
   logic [2:0]           pidx;
   logic                 setup;
   logic                 access;

   // ===================================================================
   // helpers
   function automatic logic [3:0] wait_of(input logic [3:0] f, input logic ext_ok);
      logic [3:0] w;
      w = {2'b00, f[`CSW_WAIT_MSB:`CSW_WAIT_LSB]};
      if (ext_ok && f[`CSW_EXT_BIT]) begin
         case (f[`CSW_WAIT_MSB:`CSW_WAIT_LSB])
            2'b00:   w = `CSW_WAIT_X0;
            2'b01:   w = `CSW_WAIT_X1;
            2'b10:   w = `CSW_WAIT_X2;
            default: w = `CSW_WAIT_X3;
         endcase
      end
      return w;
   endfunction

   // overlapping selects should agree; max and or keep a mismatch from shortening a cycle
   function automatic csw_pkg::csw_cfg_s merge(input csw_pkg::csw_cfg_s a,
                                               input logic [3:0] f, input logic ext_ok);
      csw_pkg::csw_cfg_s m;
      logic [3:0] w;
      w = wait_of(f, ext_ok);
      m.waits = (w > a.waits) ? w : a.waits;
      m.rdy_req = a.rdy_req | f[`CSW_RDY_BIT];
      return m;
   endfunction

   function automatic logic [31:0] read_reg(input csw_pkg::csw_state_s s,
                                            input logic [7:0] a, input logic [2:0] ph,
                                            input logic me, input logic pe);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         `CSW_OFF_UPPER:  d = {16'h0000, s.upper};
         `CSW_OFF_LOWER:  d = {16'h0000, s.lower};
         `CSW_OFF_MIDMEM: d = {16'h0000, s.midmem};
         `CSW_OFF_PBASE:  d = {16'h0000, s.pbase};
         `CSW_OFF_MIDPER: d = {16'h0000, s.midper};
         `CSW_OFF_STATUS: d = {25'h0, pe, me, s.lcs_en, (ph != 3'h0), ph};
         default:         d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   function automatic logic known(input logic [7:0] a);
      return (a == `CSW_OFF_UPPER) || (a == `CSW_OFF_LOWER) ||
             (a == `CSW_OFF_MIDMEM) || (a == `CSW_OFF_PBASE) ||
             (a == `CSW_OFF_MIDPER) || (a == `CSW_OFF_STATUS);
   endfunction

   // ===================================================================
   // address decode
   always_comb begin
      mcs_en  = st_r.mm_w && st_r.mp_w;
      pcs_en  = st_r.pb_w && st_r.mp_w;
      mem_cyc = !I_CYC_IO;
      // with midper bit 6 clear, peripheral selects decode io cycles only and never meet memory selects, even at address zero
      pcs_cyc = st_r.midper[`CSW_MSPACE_BIT] ? mem_cyc : I_CYC_IO;
      mbase   = {st_r.midmem[`CSW_MBASE_MSB:`CSW_MBASE_LSB], 13'h0000};
      msize   = 20'h02000 << st_r.midper[`CSW_MSIZE_MSB:`CSW_MSIZE_LSB];
      moff    = I_CYC_ADDR - mbase;
      pidx    = I_CYC_ADDR[10:8];
      hit     = '0;
      // dma and cpu cycles decode alike
      hit.ucs = mem_cyc && (I_CYC_ADDR[19:16] >=
                st_r.upper[`CSW_BOUND_MSB:`CSW_BOUND_LSB]);
      hit.lcs = mem_cyc && st_r.lcs_en && (I_CYC_ADDR[19:16] <=
                st_r.lower[`CSW_BOUND_MSB:`CSW_BOUND_LSB]);
      if (mem_cyc && mcs_en && I_CYC_ADDR >= mbase && moff < msize) begin
         hit.mcs[2'(moff >> (5'd11 + 5'(st_r.midper[`CSW_MSIZE_MSB:`CSW_MSIZE_LSB])))]
            = 1'b1;
      end
      if (pcs_cyc && pcs_en && pidx != 3'h7 &&
          I_CYC_ADDR[19:11] == st_r.pbase[`CSW_PBASE_MSB:`CSW_PBASE_LSB]) begin
         hit.pcs[pidx] = 1'b1;
      end
   end

   // ===================================================================
   // wait and ready setting of the access
   always_comb begin
      cfg = '0;
      // an on-chip block hit overrides every other select: zero waits and no ready
      if (I_PCB_HIT) begin
         cfg = '0;
      end else begin
         if (hit.ucs) begin
            cfg = merge(cfg, st_r.upper[3:0], 1'b0);
         end
         if (hit.lcs) begin
            cfg = merge(cfg, st_r.lower[3:0], 1'b0);
         end
         if (hit.mcs != 4'h0) begin
            cfg = merge(cfg, st_r.midmem[3:0], 1'b0);
         end
         if (hit.pcs[3:0] != 4'h0) begin
            cfg = merge(cfg, st_r.pbase[3:0], 1'b1);
         end
         if (hit.pcs[4]) begin
            cfg = merge(cfg, st_r.midper[3:0], 1'b0);
         end
         if (hit.pcs[6:5] != 2'b00 && !st_r.midper[`CSW_AMODE_BIT]) begin
            cfg = merge(cfg, st_r.midper[3:0], 1'b0);
         end
      end
      da_hit = (hit.ucs && st_r.upper[`CSW_DA_BIT]) ||
               (hit.lcs && st_r.lower[`CSW_DA_BIT]);
   end

   // ===================================================================
   // ready: async input through two flops, sync input used as is
   always_comb begin
      ready = st_r.ardy_s2 | I_SRDY;
   end

   csw_wait_gen u_wait (
      .i_clk   (I_SYS_CLK),
      .i_rst   (I_SYS_RST),
      .i_start (I_CYC_START),
      .i_cfg   (cfg),
      .i_ready (ready),
      .o_phase (phase),
      .o_done  (done)
   );

   // ===================================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      setup  = I_PSEL && !I_PENABLE;
      access = I_PSEL && I_PENABLE && st_r.pready;
      // the first flop feeds only the second
      st_nxt.ardy_s1 = I_ARDY;
      st_nxt.ardy_s2 = st_r.ardy_s1;
      // apb: answer lands one cycle after setup, with no further wait
      st_nxt.pready  = setup;
      st_nxt.pslverr = setup && !known(I_PADDR);
      st_nxt.prdata  = (setup && !I_PWRITE) ?
                       read_reg(st_r, I_PADDR, 3'(phase), mcs_en, pcs_en) : 32'h0000_0000;
      if (access && I_PWRITE) begin
         case (I_PADDR)
            `CSW_OFF_UPPER:  st_nxt.upper = I_PWDATA[15:0];
            `CSW_OFF_LOWER: begin
               st_nxt.lower  = I_PWDATA[15:0];
               st_nxt.lcs_en = 1'b1;
            end
            `CSW_OFF_MIDMEM: begin
               st_nxt.midmem = I_PWDATA[15:0];
               st_nxt.mm_w   = 1'b1;
            end
            `CSW_OFF_PBASE: begin
               st_nxt.pbase = I_PWDATA[15:0];
               st_nxt.pb_w  = 1'b1;
            end
            `CSW_OFF_MIDPER: begin
               st_nxt.midper = I_PWDATA[15:0];
               st_nxt.mp_w   = 1'b1;
            end
            default: st_nxt.upper = st_r.upper;
         endcase
      end
      // selects and address bits are captured together with the address
      st_nxt.addr_en = 1'b0;
      if (phase == csw_pkg::PH_IDLE && I_CYC_START) begin
         st_nxt.sel     = hit;
         st_nxt.amode   = st_r.midper[`CSW_AMODE_BIT];
         // in address mode the top two pins carry latched a1 and a2, else pcs5 and pcs6
         st_nxt.a1      = st_r.midper[`CSW_AMODE_BIT] ? I_CYC_ADDR[1] : !hit.pcs[5];
         st_nxt.a2      = st_r.midper[`CSW_AMODE_BIT] ? I_CYC_ADDR[2] : !hit.pcs[6];
         st_nxt.addr_en = !da_hit;
      end else if (phase == csw_pkg::PH_T4) begin
         st_nxt.sel = '0;
         // selects release after t4; latched address bits stay until the next cycle
         if (!st_r.amode) begin
            st_nxt.a1 = 1'b1;
            st_nxt.a2 = 1'b1;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SYS_RST) begin
         st_r <= '{upper: `CSW_RST_UPPER, lower: `CSW_RST_LOWER,
                   midmem: `CSW_RST_MIDMEM, pbase: `CSW_RST_PBASE,
                   midper: `CSW_RST_MIDPER, a1: 1'b1, a2: 1'b1, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ===================================================================
   // outputs
   assign O_PREADY     = st_r.pready;
   assign O_PRDATA     = st_r.prdata;
   assign O_PSLVERR    = st_r.pslverr;
   assign O_UCS_N      = !st_r.sel.ucs;
   assign O_LCS_N      = !st_r.sel.lcs;
   assign O_MCS_N      = ~st_r.sel.mcs;
   assign O_PCS_LOW_N  = ~st_r.sel.pcs[3:0];
   // both pins come straight from their flops, resolved when the cycle is captured
   assign O_PERIPH_SELECT_SECOND_N = st_r.a1;
   assign O_PERIPH_SELECT_TOP_N    = st_r.a2;
   assign O_ADDR_DRIVE_EN = st_r.addr_en;
   assign O_CYC_DONE   = done;
   assign O_PHASE      = 3'(phase);

   // ===================================================================
   // checks
   ucs_select_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (phase == csw_pkg::PH_IDLE && I_CYC_START && hit.ucs) |=> !O_UCS_N [*4])
      else $error("upper select not held through the cycle");
   lcs_idle_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      !st_r.lcs_en |-> O_LCS_N)
      else $error("lower select active before programming");
   pcs_idle_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      !pcs_en |-> (st_r.sel.pcs == 7'h00 && O_PCS_LOW_N == 4'hf))
      else $error("peripheral select active before programming");
   zero_wait_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (phase == csw_pkg::PH_IDLE && I_CYC_START && cfg == '0) |-> ##4 O_CYC_DONE)
      else $error("zero wait access not four cycles");
   waits_first_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (phase == csw_pkg::PH_IDLE && I_CYC_START && cfg.waits == 4'h2)
      |=> !O_CYC_DONE [*5])
      else $error("cycle ended before programmed waits");
   addr_off_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (phase == csw_pkg::PH_IDLE && I_CYC_START) |=> (O_ADDR_DRIVE_EN == !$past(da_hit)))
      else $error("address drive enable wrong for disable bit");
   addr_pins_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (phase == csw_pkg::PH_IDLE && I_CYC_START && st_r.midper[`CSW_AMODE_BIT])
      |=> (O_PERIPH_SELECT_SECOND_N == $past(I_CYC_ADDR[1])))
      else $error("latched a1 not on its pin");
   ext_wait_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (hit.pcs[0] && !I_PCB_HIT && st_r.pbase[3:0] == 4'hb) |-> cfg.waits >= 4'h9)
      else $error("extended wait code not decoded");
   apb_answer_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (I_PSEL && !I_PENABLE) |=> O_PREADY)
      else $error("apb answer late");
   amode_wait_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (st_r.midper[`CSW_AMODE_BIT] && I_CYC_IO && hit.pcs[4:0] == 5'h00) |-> cfg == '0)
      else $error("address pin mode left waits on the top selects");
   io_zero_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (phase == csw_pkg::PH_IDLE && I_CYC_START && I_CYC_IO)
      |=> (O_UCS_N && O_LCS_N && O_MCS_N == 4'hf))
      else $error("memory select active on an io cycle");
   pcb_zero_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (phase == csw_pkg::PH_IDLE && I_CYC_START && I_PCB_HIT) |-> ##4 O_CYC_DONE)
      else $error("on-chip block access not zero wait");
   lcs_write_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == `CSW_OFF_LOWER)
      |=> st_r.lcs_en)
      else $error("lower select not enabled by its write");
   top_pins_idle_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
      (!pcs_en && !st_r.amode) |-> (O_PERIPH_SELECT_SECOND_N && O_PERIPH_SELECT_TOP_N))
      else $error("top peripheral select active before programming");
endmodule

// ---- testbench/csw_ext_model.sv ----
`timescale 1ns/1ns
module csw_ext_model (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // select seen on the bus, active low
   input  wire logic       i_sel_n,
   // answer style: 0 sync ready, 1 async ready; cycles before ready
   input  wire logic       i_async,
   input  wire logic [3:0] i_delay,
   // ready lines
   output logic            o_srdy,
   output logic            o_ardy
);
   // ===================================================================
   // ready timing
   logic [3:0] cnt_r;
   logic       want;

   always @(posedge i_clk) begin
      if (i_rst || i_sel_n) begin
         cnt_r <= 4'h0;
      end else if (cnt_r != 4'hf) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
   // sync ready is low whenever the device is not selected, never left high
   assign want   = !i_sel_n && (cnt_r >= i_delay);
   assign o_srdy = !i_async && want;
   // async ready comes from its own flop, so it reaches the synchroniser a cycle late
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_ardy <= 1'b0;
      end else begin
         o_ardy <= i_async && want;
      end
   end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
`include "csw_regs.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_top;
   // ===================================================================
   // signals
   logic        clk, rst, psel, penable, pwrite, start, io, dma, onchip_periph_block;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        pready, pslverr, srdy, ardy, async, ucs_n, lcs_n, sec_n, top_n;
   logic        den, done, err, ddum;
   logic [19:0] caddr;
   logic [3:0]  dly, mcs_n, pcs_n;
   logic [2:0]  phase;
   logic [11:0] sel;
   int          miscompares, n_compared, cycles, len, rdy_at;
   int          xw [4] = '{5, 7, 9, 15};

   csw_top dut_u (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
      .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_CYC_START(start), .I_CYC_ADDR(caddr),
      .I_CYC_IO(io), .I_CYC_DMA(dma), .I_PCB_HIT(onchip_periph_block), .I_ARDY(ardy), .I_SRDY(srdy),
      .O_UCS_N(ucs_n), .O_LCS_N(lcs_n), .O_MCS_N(mcs_n), .O_PCS_LOW_N(pcs_n),
      .O_PERIPH_SELECT_SECOND_N(sec_n), .O_PERIPH_SELECT_TOP_N(top_n),
      .O_ADDR_DRIVE_EN(den), .O_CYC_DONE(done), .O_PHASE(phase));

   csw_ext_model ext_u (.i_clk(clk), .i_rst(rst),
      .i_sel_n(&{ucs_n, lcs_n, mcs_n, pcs_n, sec_n, top_n}),
      .i_async(async), .i_delay(dly), .o_srdy(srdy), .o_ardy(ardy));

   // ===================================================================
   // clock and cut-off
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end

   // ===================================================================
   // helpers
   function automatic void check_val(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endfunction

   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // one apb transfer; an idle cycle follows so no signal is set twice at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // one bus cycle; len is the cycle holding done, start cycle counted as 0
   task automatic cyc(input logic [19:0] a, input logic i, input logic d, input logic p);
      start <= 1'b1;
      caddr <= a;
      io <= i;
      dma <= d;
      onchip_periph_block <= p;
      @(posedge clk);
      start <= 1'b0;
      len = 0;
      rdy_at = 0;
      do begin
         @(posedge clk);
         len++;
         if (len == 1) begin
            sel = {ucs_n, lcs_n, mcs_n, pcs_n, sec_n, top_n};
            ddum = den;
         end
         if (srdy === 1'b1 && rdy_at == 0 && len >= 4) begin
            rdy_at = len;
         end
      end while (done !== 1'b1);
   endtask

   // ===================================================================
   // tests
   initial begin
      {clk, psel, penable, pwrite, start, io, dma, onchip_periph_block, async} = '0;
      {paddr, pwdata, caddr} = '0;
      dly = 4'h0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, `CSW_OFF_UPPER, 32'h0);
      `CHK(q, 32'h0000f007);
      apb(1'b0, `CSW_OFF_LOWER, 32'h0);
      `CHK(q, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      `CHK(err, 1'b1);
      `CHK(q, 32'h0);
      apb(1'b1, `CSW_OFF_MIDMEM, 32'hffffa5a5);
      apb(1'b0, `CSW_OFF_MIDMEM, 32'h0);
      `CHK(q, 32'h0000a5a5);
      $display("test registers done");
      for (int d = 0; d < 2; d++) begin
         cyc(20'hf0000, 1'b0, d[0], 1'b0);
         `CHK(len, 7);
         `CHK(phase, 3'h6);
         `CHK(sel, 12'h7ff);
         `CHK(ddum, 1'b1);
      end
      $display("test reset cycle done");
      for (int w = 0; w < 4; w++) begin
         apb(1'b1, `CSW_OFF_UPPER, 32'hf000 | w);
         cyc(20'hfff00, 1'b0, 1'b0, 1'b0);
         `CHK(len, 4 + w);
      end
      `CHK(len - 3, 4);
      $display("test waits done");
      apb(1'b1, `CSW_OFF_UPPER, 32'hf007);
      dly <= 4'h6;
      cyc(20'hf1234, 1'b0, 1'b0, 1'b0);
      `CHK(len, rdy_at + 3);
      `CHK(rdy_at > 4, 1'b1);
      apb(1'b1, `CSW_OFF_UPPER, 32'hf004);
      async <= 1'b1;
      dly <= 4'h1;
      cyc(20'hf0010, 1'b0, 1'b0, 1'b0);
      `CHK(len > 4 && len < 12, 1'b1);
      async <= 1'b0;
      dly <= 4'h0;
      $display("test ready done");
      apb(1'b1, `CSW_OFF_MIDPER, 32'h0);
      cyc(20'ha4800, 1'b0, 1'b0, 1'b0);
      `CHK(sel, 12'hf7f);
      `CHK(len, 5);
      for (int w = 0; w < 4; w++) begin
         apb(1'b1, `CSW_OFF_PBASE, 32'h0008 | w);
         cyc(20'h00100, 1'b1, 1'b0, 1'b0);
         `CHK(len, 4 + xw[w]);
      end
      apb(1'b1, `CSW_OFF_PBASE, 32'h0);
      for (int n = 0; n < 4; n++) begin
         cyc(20'h000ff + n * 256, 1'b1, 1'b0, 1'b0);
         `CHK(sel, 12'hfff ^ (12'h4 << n));
      end
      $display("test peripheral selects done");
      apb(1'b1, `CSW_OFF_UPPER, 32'hf080);
      cyc(20'hf0000, 1'b0, 1'b0, 1'b0);
      `CHK(ddum, 1'b0);
      // on-chip block overlap only with a zero-wait, no-ready upper select
      apb(1'b1, `CSW_OFF_UPPER, 32'hf000);
      cyc(20'hf0000, 1'b0, 1'b0, 1'b1);
      `CHK(len, 4);
      apb(1'b1, `CSW_OFF_LOWER, 32'h0);
      cyc(20'h00100, 1'b0, 1'b0, 1'b0);
      `CHK(sel, 12'hbff);
      cyc(20'h00000, 1'b1, 1'b0, 1'b0);
      `CHK(sel, 12'hffb);
      apb(1'b1, `CSW_OFF_MIDPER, 32'h0083);
      cyc(20'h00502, 1'b1, 1'b0, 1'b0);
      `CHK(len, 4);
      `CHK(sel[1:0], 2'b10);
      $display("test address and on-chip block done");
      complete_run();
   end
endmodule
